// ### common/bdv_pkg.sv
// Shared constants and types for the bridge driver verification logic
// How it works
// - On-line monitors always run, set result and fault bits
// - Supply-open threshold is (n+1) times 2 V
// - Supply trip sets disconnect, high-side faults, flag
// - Below threshold minus hysteresis clears flag, reenables
// - Disconnect and high-side faults stay until cleared
// - Phase comparators drive pins and state bits
// - Phase threshold is n/64 of bridge voltage
// - Open sense input sets its open bit
// - Source open sets bit, low-side fault, flag
// - Source open stops outputs when stop-on-fault is set; bits stay set
// - Off-line checks run only while command held
// - Host judges comparator test by fault bit
// - High-side test: phase high at clear sets connected
// - Connected bit updates only when command clears
// - Low-side test: phase low at clear sets connected
// - Host repeats both tests for second phase
// - Host should mask drain-source detection during tests
// - Undervoltage test trips comparator, latches fault bit
// - Overvoltage test trips comparator, latches fault bit
// - Fault bits clear only on power-on or read
package bdv_pkg;
    // ======================================================
    // Field widths and reset values
    localparam int BDV_OSEL_W = 2;
    localparam int BDV_PSEL_W = 6;
    localparam int BDV_MV_W = 16;
    localparam logic [BDV_OSEL_W-1:0] BDV_OSEL_RST = 2'h0;
    localparam logic [BDV_PSEL_W-1:0] BDV_PSEL_RST = 6'h20;
    // Supply-open threshold step, millivolts
    localparam int BDV_VBRO_STEP_MV = 2000;
    localparam int BDV_PSEL_DIV_LOG2 = 6;
    // Hysteresis and source-open threshold defaults, millivolts
    localparam int BDV_VBRO_HYS_MV = 200;
    localparam int BDV_VLSO_MV = 1000;
    localparam int BDV_VLSO_HYS_MV = 100;
    // ======================================================
    // Result and fault bit positions
    localparam int BDV_RES_W = 8;
    localparam int BDV_RES_BRIDGE = 0;
    localparam int BDV_RES_SRC_A = 1;
    localparam int BDV_RES_SRC_B = 2;
    localparam int BDV_RES_SNS_A = 3;
    localparam int BDV_RES_SNS_B = 4;
    localparam int BDV_RES_PHC = 5;
    localparam int BDV_RES_STA = 6;
    localparam int BDV_RES_STB = 7;
    localparam int BDV_DG_W = 6;
    localparam int BDV_DG_HS_A = 0;
    localparam int BDV_DG_HS_B = 1;
    localparam int BDV_DG_LS_A = 2;
    localparam int BDV_DG_LS_B = 3;
    localparam int BDV_DG_RUV = 4;
    localparam int BDV_DG_ROV = 5;
    typedef enum logic [1:0] {BDV_PT_NONE, BDV_PT_HIGH, BDV_PT_LOW} bdv_ptest_t;
endpackage : bdv_pkg

// ### common/bdv_if.sv
// Link between the verification logic and the system controller
`timescale 1ns/10ps
interface bdv_if;
    import bdv_pkg::*;
    logic [BDV_OSEL_W-1:0] bridge_open_thresh_sel;
    logic [BDV_PSEL_W-1:0] phase_thresh_sel;
    logic stop_on_fault;
    logic pull_down_test_cmd;
    logic pull_up_test_cmd;
    logic reg_uv_test_cmd;
    logic reg_ov_test_cmd;
    logic [BDV_RES_W-1:0] res_rd;
    logic [BDV_DG_W-1:0] diag_rd;
    logic [BDV_RES_W-1:0] result;
    logic [BDV_DG_W-1:0] diag;
    logic fault_flag;
    logic phase_a_level_out;
    logic phase_b_level_out;
    modport dev (
        input bridge_open_thresh_sel, phase_thresh_sel, stop_on_fault,
        input pull_down_test_cmd, pull_up_test_cmd, reg_uv_test_cmd, reg_ov_test_cmd,
        input res_rd, diag_rd,
        output result, diag, fault_flag, phase_a_level_out, phase_b_level_out
    );
    modport host (
        output bridge_open_thresh_sel, phase_thresh_sel, stop_on_fault,
        output pull_down_test_cmd, pull_up_test_cmd, reg_uv_test_cmd, reg_ov_test_cmd,
        output res_rd, diag_rd,
        input result, diag, fault_flag, phase_a_level_out, phase_b_level_out
    );
endinterface : bdv_if

// ### rtl/bdv_device.sv
// Device end: on-line monitors and off-line verification checks
`timescale 1ns/10ps
module bdv_device
    import bdv_pkg::*;
#(
    parameter int VBRO_HYS_MV = BDV_VBRO_HYS_MV,
    parameter int VLSO_MV = BDV_VLSO_MV,
    parameter int VLSO_HYS_MV = BDV_VLSO_HYS_MV
)(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_por,
    bdv_if.dev lnk,
    input wire logic [BDV_MV_W-1:0] i_main_supply_mv,
    input wire logic [BDV_MV_W-1:0] i_bridge_drain_ref_mv,
    input wire logic [BDV_MV_W-1:0] i_phase_a_mv,
    input wire logic [BDV_MV_W-1:0] i_phase_b_mv,
    input wire logic [BDV_MV_W-1:0] i_low_side_source_a_mv,
    input wire logic [BDV_MV_W-1:0] i_low_side_source_b_mv,
    input wire logic i_sense_a_open,
    input wire logic i_sense_b_open,
    input wire logic i_reg_uv,
    input wire logic i_reg_ov,
    output logic o_gate_enable
);
    import bdv_pkg::*;

    logic [BDV_MV_W:0] bro_mv;
    logic [BDV_MV_W:0] diff_mv;
    logic bridge_trip_r;
    logic [1:0] src_trip_r;
    logic [1:0] phase_hi;
    logic [BDV_RES_W-1:0] res_r;
    logic [BDV_DG_W-1:0] diag_r;
    logic [1:0] test_cmd_d_r;
    logic [BDV_RES_W-1:0] res_set;
    logic [BDV_DG_W-1:0] diag_set;
    logic [BDV_MV_W+BDV_PSEL_W-1:0] pt_scaled;
    logic [BDV_MV_W-1:0] pt_mv;
    logic [BDV_MV_W-1:0] src_mv [2];

    // ======================================================
    // Supply-to-bridge disconnect comparator
    // threshold from select field
    assign bro_mv = (BDV_MV_W+1)'((int'(lnk.bridge_open_thresh_sel) + 1) * BDV_VBRO_STEP_MV);
    assign diff_mv = (i_main_supply_mv > i_bridge_drain_ref_mv)
        ? {1'b0, i_main_supply_mv - i_bridge_drain_ref_mv} : '0;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            bridge_trip_r <= 1'b0;
        else if (diff_mv > bro_mv)
            bridge_trip_r <= 1'b1;
        else if (diff_mv + (BDV_MV_W+1)'(VBRO_HYS_MV) < bro_mv)
            bridge_trip_r <= 1'b0;
    end

    // ======================================================
    // Low-side source open comparators
    assign src_mv[0] = i_low_side_source_a_mv;
    assign src_mv[1] = i_low_side_source_b_mv;
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_src
            always_ff @(posedge i_mclk)
            begin
                if (!i_rst_n)
                    src_trip_r[g] <= 1'b0;
                else if (src_mv[g] > BDV_MV_W'(VLSO_MV))
                    src_trip_r[g] <= 1'b1;
                else if (src_mv[g] < BDV_MV_W'(VLSO_MV - VLSO_HYS_MV))
                    src_trip_r[g] <= 1'b0;
            end
        end
    endgenerate

    // ======================================================
    // Phase state comparators
    // threshold is n/64 of bridge voltage
    assign pt_scaled = i_bridge_drain_ref_mv * lnk.phase_thresh_sel;
    assign pt_mv = pt_scaled[BDV_MV_W+BDV_PSEL_W-1:BDV_PSEL_DIV_LOG2];
    assign phase_hi[0] = i_phase_a_mv > pt_mv;
    assign phase_hi[1] = i_phase_b_mv > pt_mv;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            lnk.phase_a_level_out <= 1'b0;
            lnk.phase_b_level_out <= 1'b0;
        end
        else
        begin
            lnk.phase_a_level_out <= phase_hi[0];
            lnk.phase_b_level_out <= phase_hi[1];
        end
    end

    // ======================================================
    // Phase connection test, sampled at command release
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            test_cmd_d_r <= 2'h0;
        else
            test_cmd_d_r <= {lnk.pull_up_test_cmd, lnk.pull_down_test_cmd};
    end

    // ======================================================
    // Sticky set terms
    always_comb
    begin
        res_set = '0;
        diag_set = '0;
        res_set[BDV_RES_BRIDGE] = bridge_trip_r;
        diag_set[BDV_DG_HS_A] = bridge_trip_r;
        diag_set[BDV_DG_HS_B] = bridge_trip_r;
        res_set[BDV_RES_SRC_A] = src_trip_r[0];
        res_set[BDV_RES_SRC_B] = src_trip_r[1];
        diag_set[BDV_DG_LS_A] = src_trip_r[0];
        diag_set[BDV_DG_LS_B] = src_trip_r[1];
        res_set[BDV_RES_SNS_A] = i_sense_a_open;
        res_set[BDV_RES_SNS_B] = i_sense_b_open;
        res_set[BDV_RES_PHC] =
            (test_cmd_d_r[0] && !lnk.pull_down_test_cmd && (phase_hi != 2'h0))
            || (test_cmd_d_r[1] && !lnk.pull_up_test_cmd && (phase_hi != 2'h3));
        diag_set[BDV_DG_RUV] = i_reg_uv || lnk.reg_uv_test_cmd;
        diag_set[BDV_DG_ROV] = i_reg_ov || lnk.reg_ov_test_cmd;
    end

    // ======================================================
    // Sticky registers, cleared by power-on or read; set wins
    // reset input leaves them alone
    always_ff @(posedge i_mclk)
    begin
        if (i_por)
        begin
            res_r <= '0;
            diag_r <= '0;
        end
        else
        begin
            res_r <= (res_r & ~lnk.res_rd) | res_set;
            diag_r <= (diag_r & ~lnk.diag_rd) | diag_set;
        end
    end

    assign lnk.result = {phase_hi[1], phase_hi[0], res_r[BDV_RES_PHC:0]};
    assign lnk.diag = diag_r;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            lnk.fault_flag <= 1'b0;
            o_gate_enable <= 1'b0;
        end
        else
        begin
            lnk.fault_flag <= bridge_trip_r || (src_trip_r != 2'h0)
                || lnk.reg_uv_test_cmd || lnk.reg_ov_test_cmd;
            o_gate_enable <= !(lnk.stop_on_fault
                && (bridge_trip_r || (src_trip_r != 2'h0)));
        end
    end
endmodule : bdv_device

// ### rtl/bdv_host.sv
// Controller end: drives settings and test commands, reads results
`timescale 1ns/10ps
module bdv_host
    import bdv_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    bdv_if.host lnk,
    input wire logic [BDV_OSEL_W-1:0] i_bridge_open_thresh_sel,
    input wire logic [BDV_PSEL_W-1:0] i_phase_thresh_sel,
    input wire logic i_stop_on_fault,
    input wire logic i_test_start,
    input wire logic i_test_low,
    input wire logic i_test_end,
    input wire logic i_reg_uv_test,
    input wire logic i_reg_ov_test,
    input wire logic i_read,
    output logic [BDV_RES_W-1:0] o_result,
    output logic [BDV_DG_W-1:0] o_diag,
    output logic o_fault_flag,
    output logic o_phase_connected
);
    import bdv_pkg::*;

    bdv_ptest_t pt_r;

    assign lnk.bridge_open_thresh_sel = i_bridge_open_thresh_sel;
    assign lnk.phase_thresh_sel = i_phase_thresh_sel;
    assign lnk.stop_on_fault = i_stop_on_fault;
    assign lnk.reg_uv_test_cmd = i_reg_uv_test;
    assign lnk.reg_ov_test_cmd = i_reg_ov_test;
    assign lnk.res_rd = i_read ? {BDV_RES_W{1'b1}} : '0;
    assign lnk.diag_rd = i_read ? {BDV_DG_W{1'b1}} : '0;

    // ======================================================
    // Phase test: command held until user ends it
    // user repeats per phase and side
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            pt_r <= BDV_PT_NONE;
        else
        begin
            unique case (pt_r)
                BDV_PT_NONE:
                    if (i_test_start)
                        pt_r <= i_test_low ? BDV_PT_LOW : BDV_PT_HIGH;
                BDV_PT_HIGH, BDV_PT_LOW:
                    if (i_test_end)
                        pt_r <= BDV_PT_NONE;
                default:
                    pt_r <= BDV_PT_NONE;
            endcase
        end
    end
    assign lnk.pull_down_test_cmd = (pt_r == BDV_PT_HIGH);
    assign lnk.pull_up_test_cmd = (pt_r == BDV_PT_LOW);

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_result <= '0;
            o_diag <= '0;
            o_fault_flag <= 1'b0;
            o_phase_connected <= 1'b0;
        end
        else
        begin
            o_fault_flag <= lnk.fault_flag;
            if (i_read)
            begin
                o_result <= lnk.result;
                o_diag <= lnk.diag;
                o_phase_connected <= lnk.result[BDV_RES_PHC];
            end
        end
    end
endmodule : bdv_host

// ### bench/bdv_monitor.sv
// Concurrent checks on the link between the two ends
`timescale 1ns/10ps
module bdv_monitor
    import bdv_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_por,
    input wire logic pull_down_test_cmd,
    input wire logic pull_up_test_cmd,
    input wire logic reg_uv_test_cmd,
    input wire logic reg_ov_test_cmd,
    input wire logic [BDV_RES_W-1:0] res_rd,
    input wire logic [BDV_DG_W-1:0] diag_rd,
    input wire logic [BDV_RES_W-1:0] result,
    input wire logic [BDV_DG_W-1:0] diag,
    input wire logic fault_flag,
    input wire logic phase_a_level_out,
    input wire logic phase_b_level_out
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    logic [2:0] drop_r;
    // ==========================================
    // Recent end of a phase test, either kind
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            drop_r <= 3'h0;
        else
            drop_r <= {drop_r[1:0], $fell(pull_down_test_cmd) || $fell(pull_up_test_cmd)};
    end
    // ==========================================
    // Assertions
    chk_uv_test_trip: assert property (
        $rose(reg_uv_test_cmd) |-> ##[1:2] (diag[BDV_DG_RUV] && fault_flag))
        else $error("uv test did not trip");
    chk_ov_test_trip: assert property (
        $rose(reg_ov_test_cmd) |-> ##[1:2] (diag[BDV_DG_ROV] && fault_flag))
        else $error("ov test did not trip");
    chk_result_sticky: assert property (
        1 |=> ((~result[5:0] & $past(result[5:0]) & ~$past(res_rd[5:0])) == 6'h0)
        || $past(i_por))
        else $error("result bit cleared without read");
    chk_diag_sticky: assert property (
        1 |=> ((~diag & $past(diag) & ~$past(diag_rd)) == 6'h0) || $past(i_por))
        else $error("diag bit cleared without read");
    chk_phc_at_drop: assert property (
        $rose(result[BDV_RES_PHC]) |-> drop_r != 3'h0)
        else $error("connected bit set outside test end");
    chk_high_test_pass: assert property (
        ($fell(pull_down_test_cmd) && $stable({phase_a_level_out, phase_b_level_out})
        && (phase_a_level_out || phase_b_level_out)) |-> ##[1:2] result[BDV_RES_PHC])
        else $error("high-side test pass not recorded");
    chk_low_test_pass: assert property (
        ($fell(pull_up_test_cmd) && $stable({phase_a_level_out, phase_b_level_out})
        && !(phase_a_level_out && phase_b_level_out)) |-> ##[1:2] result[BDV_RES_PHC])
        else $error("low-side test pass not recorded");
    chk_bridge_fault_set: assert property (
        $rose(result[BDV_RES_BRIDGE]) |-> diag[1:0] == 2'h3 && fault_flag)
        else $error("bridge trip without faults and flag");
    chk_source_fault_set: assert property (
        $rose(result[BDV_RES_SRC_A]) |-> diag[BDV_DG_LS_A] && fault_flag)
        else $error("source open without fault and flag");
    cov_bridge: cover property ($rose(result[BDV_RES_BRIDGE]));
    cov_phc: cover property ($rose(result[BDV_RES_PHC]));
    cov_flag_drop: cover property ($fell(fault_flag));
endmodule : bdv_monitor

// ### bench/tb_top.sv
// Self-checking bench for both ends of the verification link
`timescale 1ns/10ps
module tb_top;
    import bdv_pkg::*;
    typedef struct {logic [1:0] sel; int diff; int srcb; logic [7:0] res;
        logic [5:0] dg; logic ff;} bdv_row_t;
    bdv_row_t rows [7] = '{'{2'h0, 2100, 0, 8'h01, 6'h03, 1'h1},
        '{2'h0, 1900, 0, 8'h00, 6'h00, 1'h0}, '{2'h1, 4100, 0, 8'h01, 6'h03, 1'h1},
        '{2'h2, 5900, 0, 8'h00, 6'h00, 1'h0}, '{2'h3, 8100, 0, 8'h01, 6'h03, 1'h1},
        '{2'h3, 7900, 1100, 8'h04, 6'h08, 1'h1}, '{2'h0, 0, 900, 8'h00, 6'h00, 1'h0}};
    logic i_mclk = 0, rst_n = 0, por = 1, stop_f = 0, ts = 0, tl = 0, te = 0;
    logic uv = 0, ov = 0, rd = 0, sna = 0, snb = 0, ruv = 0, rov = 0;
    logic [1:0] open_sel = 2'h0;
    logic [5:0] ph_sel = 6'h20;
    logic [15:0] supply_mv = 16'h2EE0, drain_mv = 16'h2EE0, pa = 16'h0, pb = 16'h0;
    logic [15:0] lsa = 16'h0, lsb = 16'h0;
    logic gate_en, h_ff, h_pc;
    logic [7:0] o_res;
    logic [5:0] o_dg;
    int fail_count = 0, checks_done = 0, cyc = 0;
    bdv_if lnk();
    bdv_device u_bdv_device (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_por(por), .lnk(lnk),
        .i_main_supply_mv(supply_mv), .i_bridge_drain_ref_mv(drain_mv), .i_phase_a_mv(pa),
        .i_phase_b_mv(pb), .i_low_side_source_a_mv(lsa), .i_low_side_source_b_mv(lsb),
        .i_sense_a_open(sna), .i_sense_b_open(snb), .i_reg_uv(ruv), .i_reg_ov(rov),
        .o_gate_enable(gate_en));
    bdv_host u_bdv_host (.i_mclk(i_mclk), .i_rst_n(rst_n), .lnk(lnk),
        .i_bridge_open_thresh_sel(open_sel), .i_phase_thresh_sel(ph_sel),
        .i_stop_on_fault(stop_f),
        .i_test_start(ts), .i_test_low(tl), .i_test_end(te), .i_reg_uv_test(uv),
        .i_reg_ov_test(ov), .i_read(rd), .o_result(o_res), .o_diag(o_dg),
        .o_fault_flag(h_ff), .o_phase_connected(h_pc));
    bdv_monitor u_bdv_monitor (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_por(por),
        .pull_down_test_cmd(lnk.pull_down_test_cmd), .pull_up_test_cmd(lnk.pull_up_test_cmd),
        .reg_uv_test_cmd(lnk.reg_uv_test_cmd), .reg_ov_test_cmd(lnk.reg_ov_test_cmd),
        .res_rd(lnk.res_rd), .diag_rd(lnk.diag_rd), .result(lnk.result), .diag(lnk.diag),
        .fault_flag(lnk.fault_flag), .phase_a_level_out(lnk.phase_a_level_out),
        .phase_b_level_out(lnk.phase_b_level_out));
    always #10 i_mclk = ~i_mclk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : wt
    // Power-on clear pulse; the only way besides a read to drop sticky bits
    task automatic clr;
        @(posedge i_mclk) por <= 1'h1;
        @(posedge i_mclk) por <= 1'h0;
        wt(2);
    endtask : clr
    task automatic finish_test;
        $display("counts: %0d checks, %0d mismatches", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // Run is about 200 cycles; a hang is cut off well past that
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            finish_test;
        end
    end
    initial
    begin
        wt(4);
        @(posedge i_mclk) rst_n <= 1'h1;
        por <= 1'h0;
        stop_f <= 1'h1;
        foreach (rows[i])
        begin
            @(posedge i_mclk) open_sel <= rows[i].sel;
            drain_mv <= 16'(12000 - rows[i].diff);
            lsb <= 16'(rows[i].srcb);
            wt(4);
            chk(lnk.result & 8'h3F, rows[i].res);
            chk(8'(lnk.diag), 8'(rows[i].dg));
            chk(8'(lnk.fault_flag), 8'(rows[i].ff));
            chk(8'(gate_en), 8'(!rows[i].ff));
            @(posedge i_mclk) drain_mv <= 16'h2EE0;
            lsb <= 16'h0;
            wt(4);
            clr;
            $display("row %0d done", i);
        end
        @(posedge i_mclk) open_sel <= 2'h0;
        drain_mv <= 16'h26AC;
        wt(4);
        @(posedge i_mclk) drain_mv <= 16'h2774;
        wt(4);
        chk(8'(lnk.fault_flag), 8'h01);
        @(posedge i_mclk) drain_mv <= 16'h283C;
        wt(4);
        chk({lnk.fault_flag, gate_en, lnk.result[0], lnk.diag[1:0]}, 8'h0F);
        // Bridge back to full supply so the phase thresholds below are exact
        @(posedge i_mclk) rst_n <= 1'h0;
        drain_mv <= 16'h2EE0;
        wt(2);
        @(posedge i_mclk) rst_n <= 1'h1;
        wt(2);
        chk({lnk.result[0], lnk.diag[1:0]}, 8'h07);
        @(posedge i_mclk) rd <= 1'h1;
        @(posedge i_mclk) rd <= 1'h0;
        wt(3);
        chk({o_res[0], lnk.result[0], lnk.diag[1:0]}, 8'h08);
        chk(8'(o_dg), 8'h03);
        $display("hysteresis and clear done");
        @(posedge i_mclk) stop_f <= 1'h0;
        sna <= 1'h1;
        snb <= 1'h1;
        wt(4);
        chk({lnk.result[4:3], lnk.fault_flag}, 8'h06);
        @(posedge i_mclk) lsa <= 16'h044C;
        wt(4);
        chk({lnk.result[1], lnk.diag[2], lnk.fault_flag, gate_en}, 8'h0F);
        @(posedge i_mclk) lsa <= 16'h03B6;
        wt(4);
        chk(8'(lnk.fault_flag), 8'h01);
        @(posedge i_mclk) lsa <= 16'h0352;
        sna <= 1'h0;
        snb <= 1'h0;
        wt(4);
        chk({lnk.result[1], lnk.result[4:3], lnk.fault_flag}, 8'h0E);
        clr;
        $display("source and sense done");
        for (int k = 0; k < 2; k++)
        begin
            @(posedge i_mclk) uv <= (k == 0);
            ov <= (k == 1);
            wt(3);
            chk({lnk.fault_flag, lnk.diag}, k ? 8'h60 : 8'h50);
            chk(8'(h_ff), 8'h01);
            @(posedge i_mclk) uv <= 1'h0;
            ov <= 1'h0;
            wt(3);
            chk({lnk.fault_flag, lnk.diag}, k ? 8'h20 : 8'h10);
            chk(8'(h_ff), 8'h00);
            clr;
            $display("regulator test %0d done", k);
        end
        for (int j = 0; j < 2; j++)
        begin
            @(posedge i_mclk) ph_sel <= j ? 6'h3F : 6'h20;
            pa <= j ? 16'h2E7C : 16'h17D4;
            pb <= j ? 16'h2DE6 : 16'h170C;
            wt(4);
            chk(8'(lnk.result[7:6]), 8'h01);
            chk({lnk.phase_b_level_out, lnk.phase_a_level_out}, 8'h01);
        end
        $display("phase state done");
        for (int j = 0; j < 3; j++)
        begin
            @(posedge i_mclk) ph_sel <= 6'h20;
            tl <= (j == 2);
            pa <= (j == 0) ? 16'h1F40 : 16'h03E8;
            pb <= 16'h0;
            wt(2);
            @(posedge i_mclk) ts <= 1'h1;
            @(posedge i_mclk) ts <= 1'h0;
            wt(6);
            chk({lnk.pull_up_test_cmd, lnk.pull_down_test_cmd}, j == 2 ? 8'h2 : 8'h1);
            chk(8'(lnk.result[5]), 8'h00);
            // No drain-source stimulus while a phase test runs
            chk(8'(lnk.diag), 8'h00);
            @(posedge i_mclk) te <= 1'h1;
            @(posedge i_mclk) te <= 1'h0;
            wt(3);
            chk(8'(lnk.result[5]), 8'(j != 1));
            @(posedge i_mclk) rd <= 1'h1;
            @(posedge i_mclk) rd <= 1'h0;
            wt(2);
            chk(8'(h_pc), 8'(j != 1));
            clr;
            $display("phase test %0d done", j);
        end
        finish_test;
    end
endmodule : tb_top
